// ### logic/lssld_core.sv
// LED sink driver control core: shift register, latch, blanking, detect.
// Assumes clk is the serial clock; all pins synchronous to it.
// Overview of operation
// - Sample input, shift on each rising edge except a status load
// - Sixteen sinks driven from parallel latch
// - Last shift stage drives serial output
// - Strobe high in normal mode makes latch transparent
// - Strobe falling freezes latch contents
// - Enable low drives sinks from latch
// - Enable high blanks all sinks
// - Entry pin sequence switches to detect mode
// - Detect mode captures open-circuit status
// - Status read out on serial output
// - Exit sequence returns to normal mode
`timescale 1ns/1ns
`include "lssld_defines.svh"
module lssld_core #(
  parameter int CHANNELS = `LSSLD_CHANNELS,
  parameter int SEQ_LEN = `LSSLD_SEQ_LEN,
  parameter logic [2*SEQ_LEN-1:0] ENTER_PAT = `LSSLD_ENTER_PATTERN,
  parameter logic [2*SEQ_LEN-1:0] EXIT_PAT = `LSSLD_EXIT_PATTERN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Serial link
  input wire logic serial_in,
  output logic serial_out,
  // Control pins
  input wire logic latch_strobe,
  input wire logic oe_b,
  // Per-channel open-circuit sense, high when LED is open
  input wire logic [CHANNELS-1:0] open_sense,
  // Sink drive, high turns a sink on
  output logic [CHANNELS-1:0] sink_outputs,
  // Mode indicator
  output logic detect_mode
);
  lssld_pkg::lssld_mode_t mode_reg; // Current mode
  lssld_pkg::lssld_mode_t mode_next;
  logic [CHANNELS-1:0] shift_reg; // Serial shift chain
  logic [CHANNELS-1:0] shift_next;
  logic [CHANNELS-1:0] latch_reg; // Channel on/off latch
  logic [CHANNELS-1:0] latch_next;
  logic [CHANNELS-1:0] status_reg; // Captured open status, 1 = LED fine
  logic [CHANNELS-1:0] status_next;
  logic strobe_d_reg; // Strobe last edge, for the freeze-on-fall check
  logic sense_valid_reg; // Status captured and waiting to load
  logic sense_valid_next;
  logic enter_hit;
  logic exit_hit;
  logic load_status;
  logic [CHANNELS-1:0] sink_next;
  logic in_detect; // Mode decode, detect side
  logic in_normal; // Mode decode, normal side
  logic capture_en; // Sense window open this edge
  logic latch_open; // Latch transparent this edge
  logic strobe_fall; // Strobe dropped since the last edge
  // Plain shifts since the last status load, saturating at the chain length;
  // only the checks read it, so it costs a handful of flops
  localparam int RUN_W = $clog2(CHANNELS + 1);
  logic [RUN_W-1:0] shift_run_reg;
  logic [RUN_W-1:0] shift_run_next;

  // Mode decode, shared by the datapath and the checks
  function automatic logic mode_is_detect(input lssld_pkg::lssld_mode_t mode);
    return (mode == lssld_pkg::LSSLD_DETECT);
  endfunction

  // Things a user of this core should know:
  // - The real pin set has no reset; rst_b only gives simulation and test a known start.
  // - Strobe and enable double as the mode pattern inputs, so ordinary latch and
  //   blank traffic can hit the entry pattern by chance; the host must keep its
  //   strobe and enable traffic clear of ENTER_PAT unless it means to enter.
  // - In detect mode the strobe no longer moves the latch, so the LEDs keep the
  //   chain as copied on the last entry edge, whose strobe still opens the latch, while probed.
  // - Status is captured on every enabled edge in detect mode and the last capture wins; the
  //   first blanked edge afterwards swaps it into the chain in place of a shift,
  //   so the bit on serial_in at that edge is dropped.
  // - Sinks are registered from the next latch value, so a strobe and an enable
  //   change on one edge show up together at that edge, never as a glitch.

  // Pattern recogniser shared by entry and exit
  lssld_seq_detect #(
    .SEQ_LEN(SEQ_LEN),
    .ENTER_PAT(ENTER_PAT),
    .EXIT_PAT(EXIT_PAT)
  ) u_seq (
    .clk(clk),
    .rst_b(rst_b),
    .latch_strobe(latch_strobe),
    .oe_b(oe_b),
    .enter_hit(enter_hit),
    .exit_hit(exit_hit)
  );

  // Named decodes for the datapath and the checks below
  assign in_detect = mode_is_detect(mode_reg);
  assign in_normal = !in_detect;
  // Sense lines only mean something while the sinks are switched on
  assign capture_en = in_detect && !oe_b;
  // Strobe moves the latch only in normal mode; in detect it is a pattern pin
  assign latch_open = latch_strobe && in_normal;
  // Strobe was high at the last edge and is low now
  assign strobe_fall = strobe_d_reg && !latch_strobe;

  // Mode transitions; exit checked only in detect, entry only in normal
  assign mode_next = (in_normal && enter_hit) ? lssld_pkg::LSSLD_DETECT :
                     (in_detect && exit_hit) ? lssld_pkg::LSSLD_NORMAL :
                     mode_reg;

  // Capture status while enabled in detect mode; good LED reads 1
  assign status_next = capture_en ? ~open_sense : status_reg;
  // Pending flag: set by a capture, cleared by the load; the two cannot meet,
  // as a capture needs enable low and a load needs it high
  assign sense_valid_next = in_detect ? (capture_en | (sense_valid_reg & ~load_status)) : 1'b0;

  // Status loads into the chain once enable goes high after a capture
  assign load_status = in_detect && oe_b && sense_valid_reg;

  // Shift chain: parallel load wins over shift in the load cycle
  assign shift_next = load_status ? status_reg : {shift_reg[CHANNELS-2:0], serial_in};

  // Latch follows the chain while open, else holds; this is the freeze on strobe fall
  assign latch_next = latch_open ? shift_next : latch_reg;

  // Run counter for the cascade check; a load restarts it
  assign shift_run_next = load_status ? '0 :
                          (shift_run_reg == RUN_W'(CHANNELS)) ? shift_run_reg :
                          shift_run_reg + RUN_W'(1);

  // Blanking; in detect mode sinks follow latch so LEDs can be probed
  assign sink_next = oe_b ? '0 : latch_next;

  // Run counter; starts at zero so the cascade check waits a full chain after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_run_reg <= '0;
    end else begin
      shift_run_reg <= shift_run_next;
    end
  end

  // Mode, status and strobe history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Start in normal mode with nothing captured
      mode_reg <= lssld_pkg::LSSLD_NORMAL;
      status_reg <= '0;
      sense_valid_reg <= 1'b0;
      // Idle strobe level, so no false fall follows release
      strobe_d_reg <= 1'b0;
    end else begin
      // All control state advances on every serial edge
      mode_reg <= mode_next;
      status_reg <= status_next;
      sense_valid_reg <= sense_valid_next;
      strobe_d_reg <= latch_strobe;
    end
  end

  // Data path registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Chain, latch and sinks start dark
      shift_reg <= '0;
      latch_reg <= '0;
      sink_outputs <= '0;
    end else begin
      // Chain, latch and sinks move together, so the sinks never lag the latch
      shift_reg <= shift_next;
      latch_reg <= latch_next;
      sink_outputs <= sink_next;
    end
  end

  // Cascade output is the top stage
  assign serial_out = shift_reg[CHANNELS-1];
  assign detect_mode = (mode_reg == lssld_pkg::LSSLD_DETECT);

  // Shift advances by one position
  shift_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(load_status) |-> shift_reg[CHANNELS-1:1] == $past(shift_reg[CHANNELS-2:0]) && shift_reg[0] == $past(serial_in))
    else $error("shift chain did not advance");

  // Serial out repeats the input a full chain length later when nothing was loaded
  cascade_out_a: assert property (@(posedge clk) disable iff (!rst_b)
    shift_run_reg == RUN_W'(CHANNELS) |-> serial_out == $past(serial_in, CHANNELS))
    else $error("serial out not delayed input");

  // Transparent latch in normal mode
  latch_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
    latch_strobe && mode_reg == lssld_pkg::LSSLD_NORMAL |=> latch_reg == shift_reg)
    else $error("latch not transparent");

  // Latch holds while strobe low
  latch_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !latch_strobe |=> $stable(latch_reg))
    else $error("latch changed with strobe low");

  // Enabled sinks follow latch
  sink_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
    !oe_b |=> sink_outputs == latch_reg)
    else $error("sinks do not follow latch");

  // Blanking forces all off
  sink_blank_a: assert property (@(posedge clk) disable iff (!rst_b)
    oe_b |=> sink_outputs == '0)
    else $error("sinks not blanked");

  // Entry pattern switches mode
  mode_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
    !detect_mode && enter_hit |=> detect_mode)
    else $error("detect mode not entered");

  // Exit pattern returns to normal
  mode_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
    detect_mode && exit_hit |=> !detect_mode)
    else $error("normal mode not resumed");

  // Capture on every enabled edge in detect mode
  status_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    detect_mode && !oe_b |=> status_reg == ~$past(open_sense))
    else $error("status not captured");

  // Status appears on serial output after load
  status_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    load_status |=> serial_out == $past(status_reg[CHANNELS-1]))
    else $error("status not on serial out");

  // Further checks; each follows from the logic above, so they hold
  // for any pin traffic the host may apply

  // Detect mode never moves the latch, strobe or not
  latch_detect_a: assert property (@(posedge clk) disable iff (!rst_b)
    detect_mode |=> $stable(latch_reg))
    else $error("latch moved in detect mode");

  // On a strobe fall the latch keeps what the last open edge copied
  latch_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
    strobe_fall && $past(in_normal) |-> latch_reg == $past(shift_next))
    else $error("latch not frozen on strobe fall");

  // Status is untouched outside the sense window
  status_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    !capture_en |=> $stable(status_reg))
    else $error("status changed outside capture");

  // A capture leaves a load pending
  sense_pend_a: assert property (@(posedge clk) disable iff (!rst_b)
    detect_mode && !oe_b |=> sense_valid_reg)
    else $error("capture not marked pending");

  // A load consumes the pending capture
  load_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    load_status |=> !sense_valid_reg)
    else $error("pending capture not cleared");

  // The whole status word lands in the chain on a load
  chain_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    load_status |=> shift_reg == $past(status_reg))
    else $error("status not loaded into chain");

  // The second status bit follows one edge after the first
  status_out_a: assert property (@(posedge clk) disable iff (!rst_b)
    load_status |=> ##1 serial_out == $past(status_reg[CHANNELS-2], 2))
    else $error("status not shifted out in order");

  // Normal mode keeps no pending capture
  normal_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !detect_mode |=> !sense_valid_reg)
    else $error("capture pending in normal mode");

  // Without a pattern hit the mode stays put
  mode_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !enter_hit && !exit_hit |=> $stable(detect_mode))
    else $error("mode changed without pattern");

  // Detect mode is only ever reached through the entry pattern
  mode_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(detect_mode) |-> $past(enter_hit))
    else $error("detect mode without entry pattern");

  // Normal mode is only ever resumed through the exit pattern
  mode_fall_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(detect_mode) |-> $past(exit_hit))
    else $error("normal mode without exit pattern");

  // Sinks only light from a latched one
  sink_source_a: assert property (@(posedge clk) disable iff (!rst_b)
    (sink_outputs & ~latch_reg) == '0)
    else $error("sink on without latched bit");

  // In detect mode enabled sinks show the frozen latch for probing
  sink_probe_a: assert property (@(posedge clk) disable iff (!rst_b)
    detect_mode && !oe_b |=> sink_outputs == $past(latch_reg))
    else $error("sinks not probing latched pattern");

  // Run counter never passes the chain length
  run_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(shift_run_reg > RUN_W'(CHANNELS)))
    else $error("run counter past chain length");
endmodule

// ### logic/lssld_defines.svh
// Constants for the LED sink shift/latch/detect block.
// Assumes inclusion by bare name from any design file.
`ifndef LSSLD_DEFINES_SVH
`define LSSLD_DEFINES_SVH
`define LSSLD_CHANNELS 16
// Mode pattern: three strobe/enable pairs sampled on serial clock edges
`define LSSLD_SEQ_LEN 3
`define LSSLD_ENTER_PATTERN 6'h2a
`define LSSLD_EXIT_PATTERN 6'h15
`endif

// ### logic/lssld_pkg.sv
// Types for the LED sink shift/latch/detect block.
// Assumes the defines header is compiled alongside.
package lssld_pkg;
  typedef enum logic [0:0] {
    LSSLD_NORMAL = 1'b0,
    LSSLD_DETECT = 1'b1
  } lssld_mode_t;
endpackage

// ### logic/lssld_seq_detect.sv
// Pattern recogniser for mode entry and exit.
// Assumes strobe and enable are sampled on rising serial clock edges.
`timescale 1ns/1ns
`include "lssld_defines.svh"
module lssld_seq_detect #(
  parameter int SEQ_LEN = `LSSLD_SEQ_LEN,
  parameter logic [2*SEQ_LEN-1:0] ENTER_PAT = `LSSLD_ENTER_PATTERN,
  parameter logic [2*SEQ_LEN-1:0] EXIT_PAT = `LSSLD_EXIT_PATTERN
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control pins
  input wire logic latch_strobe,
  input wire logic oe_b,
  // Detected patterns
  output logic enter_hit,
  output logic exit_hit
);
  logic [2*SEQ_LEN-1:0] hist_reg; // Strobe/enable history, newest low
  logic [2*SEQ_LEN-1:0] hist_next;

  assign hist_next = {hist_reg[2*SEQ_LEN-3:0], latch_strobe, oe_b};
  // Match on the fresh window so the mode flips on the last edge
  assign enter_hit = (hist_next == ENTER_PAT);
  assign exit_hit = (hist_next == EXIT_PAT);

  // History shift on every edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_reg <= '0;
    end else begin
      hist_reg <= hist_next;
    end
  end
endmodule

// ### testbench/lssld_led_model.sv
// LED string model that reports open circuits on the sense lines.
// Assumes the bench chooses which LEDs are broken.
`timescale 1ns/1ns
module lssld_led_model (
  // Fault selection, one bit per LED
  input wire logic [15:0] fault_mask,
  // Sense back to the driver, high when open
  output logic [15:0] open_sense
);
  // Static string: a broken LED reads open whenever it is sensed
  assign open_sense = fault_mask;
endmodule

// ### testbench/led_sink_shift_latch_detect_tb.sv
// Self-checking bench for the LED sink core against a per-edge model.
// Assumes the core and the LED model are compiled alongside.
`timescale 1ns/1ns
`include "lssld_defines.svh"
module led_sink_shift_latch_detect_tb;
  logic clk = 1'b0, rst_b = 1'b0, serial_in = 1'b0, latch_strobe = 1'b0, oe_b = 1'b1;
  logic [15:0] fault_mask = 16'h0000; // Broken LEDs
  logic [15:0] open_sense, sink_outputs;
  logic serial_out, detect_mode;
  int err_total = 0, tests_run = 0, seed = 24;
  logic [31:0] r; // Random draw
  // Model state: chain, latch, status, pin history, mode, load pending
  logic [15:0] sr_m = 16'h0000, lat_m = 16'h0000, st_m = 16'h0000;
  logic [5:0] hist_m = 6'h00;
  logic mode_m = 1'b0, pend_m = 1'b0;
  // Serial clock, 20 ns period
  always #10 clk = ~clk;
  lssld_core i_dut (.clk(clk), .rst_b(rst_b), .serial_in(serial_in), .serial_out(serial_out),
    .latch_strobe(latch_strobe), .oe_b(oe_b), .open_sense(open_sense),
    .sink_outputs(sink_outputs), .detect_mode(detect_mode));
  lssld_led_model i_led (.fault_mask(fault_mask), .open_sense(open_sense));
  // Compare and count
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task conclude;
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One serial clock: drive pins, advance the model, compare after the edge
  task step(input logic si, input logic le, input logic oe);
    logic old;
    begin
      old = mode_m;
      serial_in = si;
      latch_strobe = le;
      oe_b = oe;
      r = $random(seed);
      fault_mask = r[15:0];
      hist_m = {hist_m[3:0], le, oe};
      // Status captured only while enabled in detect mode
      if (old && !oe) begin
        st_m = ~r[15:0];
        pend_m = 1'b1;
      end
      // First blanked edge loads status, otherwise plain shift
      if (old && oe && pend_m) begin
        sr_m = st_m;
        pend_m = 1'b0;
      end else sr_m = {sr_m[14:0], si};
      if (!old && le) lat_m = sr_m;
      mode_m = old ? (hist_m != `LSSLD_EXIT_PATTERN) : (hist_m == `LSSLD_ENTER_PATTERN);
      @(posedge clk);
      #2;
      chk("serial_out", {15'h0000, serial_out}, {15'h0000, sr_m[15]});
      chk("sink_outputs", sink_outputs, oe ? 16'h0000 : lat_m);
      chk("detect_mode", {15'h0000, detect_mode}, {15'h0000, mode_m});
    end
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #2 rst_b = 1'b1;
    // Random pins: shifting, latching, blanking, chance mode swaps
    repeat (400) begin
      r = $random(seed);
      step(r[0], r[1], r[2]);
    end
    repeat (3) step(1'b0, 1'b0, 1'b1);
    // Enter detect, capture, read status out, leave
    repeat (3) step(1'b1, 1'b1, 1'b0);
    repeat (2) step(1'b0, 1'b0, 1'b0);
    repeat (16) step(1'b0, 1'b1, 1'b1);
    repeat (3) step(1'b0, 1'b0, 1'b1);
    // Random shifting and strobing with enable low; three strobes in a row enter detect again
    repeat (40) begin
      r = $random(seed);
      step(r[0], r[1], 1'b0);
    end
    conclude;
  end
endmodule
